// ==== ursf_pkg.sv ====
// What this block does
// [RULE1] Address detect works only when its enable is set and 9-bit mode is on.
// [RULE2] In address detect mode only characters whose ninth bit is one are accepted.
// [RULE3] Receiver idle flag reads one while idle, zero while a character arrives.
// [RULE4] Parity error flag belongs to the character at the receive FIFO head.
// [RULE5] Framing error flag belongs to the character at the receive FIFO head.
// [RULE6] Overrun flag sets when the receive buffer overflows, otherwise stays zero.
// [RULE7] Clearing a set overrun flag empties the receive buffer and shift register.
// [RULE8] Software may read and clear the overrun flag but never set it.
// [RULE9] Data available reads one while unread characters remain, zero when empty.
// [RULE10] After a read, error flags follow the new head character, or clear.
// [RULE11] While overrun is set, new characters are dropped and the buffer kept.
package ursf_pkg;

    // ==========================================================
    // Clock and default bit rate
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_DEFAULT = 115_200;
    localparam logic [15:0] DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT);

    // ==========================================================
    // Register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_RXDATA = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] OFF_DIV = 8'h14;

    // ==========================================================
    // Field positions of uart_status_control
    localparam int B_RXDA = 0;
    localparam int B_OVERRUN_ERROR_FLAG = 1;
    localparam int B_FRAMING_ERROR_FLAG = 2;
    localparam int B_PARITY_ERROR_FLAG = 3;
    localparam int B_RECEIVER_IDLE_FLAG = 4;
    localparam int B_ADDRESS_DETECT_ENABLE = 5;
    localparam int B_NINE = 8;
    localparam int B_PAREN = 9;

    // ==========================================================
    // Interrupt bits and bus answers
    localparam int IRQ_W = 3;
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_ERR = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Character layout
    localparam int CHAR_W = 9;
    localparam int ADDR_BIT = 8;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;

    // ==========================================================
    // Receiver states
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } ursf_rx_st_t;

endpackage

// ==== ursf_rx_shift.sv ====
`timescale 1ns/1ps
module ursf_rx_shift import ursf_pkg::*; (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Line and setup
    input wire logic i_rxd,
    input wire logic [15:0] i_div,
    input wire logic i_nine,
    input wire logic i_par_en,
    input wire logic i_flush,
    // Received character
    output logic o_done,
    output logic [CHAR_W-1:0] o_data,
    output logic o_parity_error_flag,
    output logic o_framing_error_flag,
    output logic o_idle
);

    // ==========================================================
    // Line synchroniser
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic nxt_lvl;

    // Level changes only once the two later stages agree
    always_comb begin
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
            lvl_ff <= 1'b1;
        end else if (i_ce) begin
            s1_ff <= i_rxd;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    // ==========================================================
    // Character framing
    ursf_rx_st_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [3:0] bit_ff, nxt_bit;
    logic [CHAR_W-1:0] sh_ff, nxt_sh, data_ff, nxt_data;
    logic par_ff, nxt_par, done_ff, nxt_done, parity_error_flag_ff, nxt_parity_error_flag, framing_error_flag_ff, nxt_framing_error_flag;
    logic bit_end;

    // Sample at mid-bit: half a bit after the start edge, then whole bits
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + 16'h0001;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_data = data_ff;
        nxt_par = par_ff;
        nxt_done = 1'b0;
        nxt_parity_error_flag = parity_error_flag_ff;
        nxt_framing_error_flag = framing_error_flag_ff;
        bit_end = (cnt_ff >= i_div - 16'h0001);
        unique case (st_ff)
            RX_IDLE: begin
                nxt_cnt = 16'h0000;
                if (!lvl_ff) begin
                    nxt_st = RX_START;
                end
            end
            RX_START: begin
                if (cnt_ff >= (i_div >> 1)) begin
                    nxt_cnt = 16'h0000;
                    nxt_bit = 4'h0;
                    // A glitch shorter than half a bit is not a start
                    nxt_st = lvl_ff ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (bit_end) begin
                    nxt_cnt = 16'h0000;
                    nxt_sh = {lvl_ff, sh_ff[CHAR_W-1:1]};
                    nxt_bit = bit_ff + 4'h1;
                    if (bit_ff == (i_nine ? LAST_BIT_9 : LAST_BIT_8)) begin
                        nxt_st = i_par_en ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (bit_end) begin
                    nxt_cnt = 16'h0000;
                    nxt_par = lvl_ff;
                    nxt_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (bit_end) begin
                    nxt_cnt = 16'h0000;
                    nxt_done = 1'b1;
                    nxt_data = i_nine ? sh_ff : {1'b0, sh_ff[CHAR_W-1:1]};
                    // Even parity over data and parity bit
                    nxt_parity_error_flag = i_par_en & ((^nxt_data) ^ par_ff);
                    nxt_framing_error_flag = ~lvl_ff;
                    nxt_st = RX_IDLE;
                end
            end
            default: begin
                nxt_st = RX_IDLE;
            end
        endcase
        // Overrun clear empties the shift register too
        if (i_flush) begin // RULE7
            nxt_st = RX_IDLE;
            nxt_cnt = 16'h0000;
            nxt_sh = '0;
            nxt_done = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_ff <= RX_IDLE;
            cnt_ff <= 16'h0000;
            bit_ff <= 4'h0;
            sh_ff <= '0;
            data_ff <= '0;
            par_ff <= 1'b0;
            done_ff <= 1'b0;
            parity_error_flag_ff <= 1'b0;
            framing_error_flag_ff <= 1'b0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            data_ff <= nxt_data;
            par_ff <= nxt_par;
            done_ff <= nxt_done;
            parity_error_flag_ff <= nxt_parity_error_flag;
            framing_error_flag_ff <= nxt_framing_error_flag;
        end
    end

    assign o_done = done_ff;
    assign o_data = data_ff;
    assign o_parity_error_flag = parity_error_flag_ff;
    assign o_framing_error_flag = framing_error_flag_ff;
    assign o_idle = (st_ff == RX_IDLE); // RULE3

    // ==========================================================
    // Checks
    property p_idle_drops;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && st_ff == RX_IDLE && !lvl_ff && !i_flush) |=> !o_idle;
    endproperty
    a_idle_drops: assert property (p_idle_drops) else $error("idle flag kept on start"); // RULE3

endmodule // ursf_rx_shift

// ==== ursf_uart_rx_status.sv ====
`timescale 1ns/1ps
module ursf_uart_rx_status import ursf_pkg::*; #(
    parameter int FIFO_DEPTH = 4,
    parameter logic [15:0] DIV_RESET = DIV_RST
) (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic [2:0] i_s_axi_awprot,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input wire logic [2:0] i_s_axi_arprot,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Serial line and interrupt
    input wire logic i_rxd,
    output logic o_irq
);

    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam int ENT_W = CHAR_W + 2;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

    // ==========================================================
    // Helpers
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a[ADDR_W-1:2] == off[ADDR_W-1:2];
    endfunction

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    // ==========================================================
    // Receiver
    logic rx_done, rx_parity_error_flag, rx_framing_error_flag, rx_idle, flush;
    logic [CHAR_W-1:0] rx_data;
    logic nine_ff, par_en_ff, addr_en_ff;
    logic [15:0] div_ff;

    ursf_rx_shift u_rx (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_rxd(i_rxd),
        .i_div(div_ff),
        .i_nine(nine_ff),
        .i_par_en(par_en_ff),
        .i_flush(flush),
        .o_done(rx_done),
        .o_data(rx_data),
        .o_parity_error_flag(rx_parity_error_flag),
        .o_framing_error_flag(rx_framing_error_flag),
        .o_idle(rx_idle)
    );

    // ==========================================================
    // Receive FIFO and overrun
    logic [ENT_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic overrun_error_flag_ff, nxt_overrun_error_flag;
    logic addr_mode, rx_ok, full, push, pop, ovf, clr_req;
    logic [ENT_W-1:0] head;
    logic head_parity_error_flag, head_framing_error_flag, avail;
    logic ar_hs;

    // Address mode exists only with 9-bit characters
    assign addr_mode = addr_en_ff & nine_ff; // RULE1
    assign rx_ok = rx_done & ~(addr_mode & ~rx_data[ADDR_BIT]); // RULE2
    assign full = (cnt_ff == CNT_FULL);
    assign avail = (cnt_ff != '0); // RULE9
    assign pop = ar_hs & hit(i_s_axi_araddr, OFF_RXDATA) & avail;
    // Dropped while overrun stands, buffered data untouched
    assign push = rx_ok & ~overrun_error_flag_ff & (~full | pop); // RULE11
    assign ovf = rx_ok & ~overrun_error_flag_ff & full & ~pop; // RULE6
    // Overrun is only set here, so a clear never races a set
    assign flush = clr_req & ~ovf; // RULE7
    assign head = mem[rd_ptr_ff];
    // Empty FIFO shows no errors; head moves on each data register read while not empty
    assign head_parity_error_flag = avail & head[CHAR_W + 1]; // RULE4 RULE10
    assign head_framing_error_flag = avail & head[CHAR_W]; // RULE5 RULE10

    always_comb begin
        nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
        nxt_cnt = cnt_ff + CNT_W'(push) - CNT_W'(pop);
        // Hardware sets, software can only clear
        nxt_overrun_error_flag = ovf | (overrun_error_flag_ff & ~clr_req); // RULE6 RULE8
        if (flush) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
            overrun_error_flag_ff <= 1'b0;
        end else if (i_ce) begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff <= nxt_cnt;
            overrun_error_flag_ff <= nxt_overrun_error_flag;
        end
    end

    // Storage needs no reset; count gates every read of it
    always_ff @(posedge i_mclk) begin
        if (i_ce && push) begin
            mem[wr_ptr_ff] <= {rx_parity_error_flag, rx_framing_error_flag, rx_data};
        end
    end

    // ==========================================================
    // Bus slave and registers
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
    logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic nxt_nine, nxt_par_en, nxt_addr_en;
    logic [15:0] nxt_div;
    logic [IRQ_W-1:0] irq_en_ff, nxt_irq_en, irq_stat_ff, nxt_irq_stat, irq_clr, irq_ev;
    logic aw_hs, w_hs, wr_go;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd, status;
    logic [3:0] ws;

    assign o_s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign o_s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign o_s_axi_arready = ~rvalid_ff;
    assign aw_hs = i_s_axi_awvalid & o_s_axi_awready;
    assign w_hs = i_s_axi_wvalid & o_s_axi_wready;
    assign ar_hs = i_s_axi_arvalid & o_s_axi_arready;
    // Address and data may come in either order
    assign wr_go = (aw_got_ff | aw_hs) & (w_got_ff | w_hs);
    assign wa = aw_got_ff ? awaddr_ff : i_s_axi_awaddr;
    assign wd = w_got_ff ? wdata_ff : i_s_axi_wdata;
    assign ws = w_got_ff ? wstrb_ff : i_s_axi_wstrb;
    // Writing zero to a set overrun bit is the only clear
    assign clr_req = wr_go & hit(wa, OFF_STATUS) & ws[0] & ~wd[B_OVERRUN_ERROR_FLAG] & overrun_error_flag_ff; // RULE7 RULE8
    assign irq_ev = {push & (rx_parity_error_flag | rx_framing_error_flag), ovf, push};

    always_comb begin
        status = '0;
        status[B_RXDA] = avail; // RULE9
        status[B_OVERRUN_ERROR_FLAG] = overrun_error_flag_ff; // RULE6
        status[B_FRAMING_ERROR_FLAG] = head_framing_error_flag; // RULE5
        status[B_PARITY_ERROR_FLAG] = head_parity_error_flag; // RULE4
        status[B_RECEIVER_IDLE_FLAG] = rx_idle; // RULE3
        status[B_ADDRESS_DETECT_ENABLE] = addr_en_ff;
        status[B_NINE] = nine_ff;
        status[B_PAREN] = par_en_ff;
    end

    always_comb begin
        nxt_aw_got = wr_go ? 1'b0 : (aw_got_ff | aw_hs);
        nxt_w_got = wr_go ? 1'b0 : (w_got_ff | w_hs);
        nxt_awaddr = aw_hs ? i_s_axi_awaddr : awaddr_ff;
        nxt_wdata = w_hs ? i_s_axi_wdata : wdata_ff;
        nxt_wstrb = w_hs ? i_s_axi_wstrb : wstrb_ff;
        nxt_bvalid = bvalid_ff & ~i_s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff & ~i_s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_nine = nine_ff;
        nxt_par_en = par_en_ff;
        nxt_addr_en = addr_en_ff;
        nxt_div = div_ff;
        nxt_irq_en = irq_en_ff;
        irq_clr = '0;
        // Register writes, per byte lane
        if (wr_go) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (hit(wa, OFF_STATUS)) begin
                if (ws[0]) nxt_addr_en = wd[B_ADDRESS_DETECT_ENABLE];
                if (ws[1]) nxt_nine = wd[B_NINE];
                if (ws[1]) nxt_par_en = wd[B_PAREN];
            end else if (hit(wa, OFF_DIV)) begin
                if (ws[0]) nxt_div[7:0] = wd[7:0];
                if (ws[1]) nxt_div[15:8] = wd[15:8];
            end else if (hit(wa, OFF_IRQ_EN)) begin
                if (ws[0]) nxt_irq_en = wd[IRQ_W-1:0];
            end else if (hit(wa, OFF_IRQ_CLR)) begin
                if (ws[0]) irq_clr = wd[IRQ_W-1:0];
            end else if (!hit(wa, OFF_RXDATA) && !hit(wa, OFF_IRQ_STAT)) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        // Register reads; the data register pops the head
        if (ar_hs) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = '0;
            if (hit(i_s_axi_araddr, OFF_STATUS)) begin
                nxt_rdata = status;
            end else if (hit(i_s_axi_araddr, OFF_RXDATA)) begin
                nxt_rdata[CHAR_W-1:0] = avail ? head[CHAR_W-1:0] : '0;
            end else if (hit(i_s_axi_araddr, OFF_IRQ_STAT)) begin
                nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
            end else if (hit(i_s_axi_araddr, OFF_IRQ_EN)) begin
                nxt_rdata[IRQ_W-1:0] = irq_en_ff;
            end else if (hit(i_s_axi_araddr, OFF_DIV)) begin
                nxt_rdata[15:0] = div_ff;
            end else if (!hit(i_s_axi_araddr, OFF_IRQ_CLR)) begin
                nxt_rresp = RESP_SLVERR;
            end
        end
        // New events win over a clear in the same cycle
        nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            nine_ff <= 1'b0;
            par_en_ff <= 1'b0;
            addr_en_ff <= 1'b0;
            div_ff <= DIV_RESET;
            irq_en_ff <= '0;
            irq_stat_ff <= '0;
        end else if (i_ce) begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            nine_ff <= nxt_nine;
            par_en_ff <= nxt_par_en;
            addr_en_ff <= nxt_addr_en;
            div_ff <= nxt_div;
            irq_en_ff <= nxt_irq_en;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign o_s_axi_bvalid = bvalid_ff;
    assign o_s_axi_bresp = bresp_ff;
    assign o_s_axi_rvalid = rvalid_ff;
    assign o_s_axi_rdata = rdata_ff;
    assign o_s_axi_rresp = rresp_ff;
    assign o_irq = |(irq_stat_ff & irq_en_ff);

    // ==========================================================
    // Checks
    sequence s_overflow;
        ovf ##1 overrun_error_flag_ff;
    endsequence

    property p_ovf_sets;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && ovf) |-> s_overflow;
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("overflow left flag clear"); // RULE6

    property p_overrun_error_flag_only_hw;
        @(posedge i_mclk) disable iff (!i_rst_n)
        $rose(overrun_error_flag_ff) |-> $past(ovf);
    endproperty
    a_overrun_error_flag_only_hw: assert property (p_overrun_error_flag_only_hw) else $error("bad overrun set"); // RULE8

    sequence s_flushed;
        (cnt_ff == '0) && rx_idle && !overrun_error_flag_ff;
    endsequence

    property p_flush_empties;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && flush) |=> s_flushed;
    endproperty
    a_flush_empties: assert property (p_flush_empties) else $error("flush incomplete"); // RULE7

    property p_avail_after_push;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && push && !flush) |=> status[B_RXDA];
    endproperty
    a_avail_after_push: assert property (p_avail_after_push) else $error("no data flag"); // RULE9

    property p_drop_in_overrun;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && overrun_error_flag_ff && !flush) |=> (cnt_ff <= $past(cnt_ff)) && $stable(wr_ptr_ff);
    endproperty
    a_drop_in_overrun: assert property (p_drop_in_overrun) else $error("kept storing"); // RULE11

    property p_addr_filter;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && rx_done && addr_mode && !rx_data[ADDR_BIT]) |-> !push;
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("data char taken"); // RULE2

    property p_eight_bit_no_filter;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && rx_done && !nine_ff && !overrun_error_flag_ff && !full) |-> push;
    endproperty
    a_eight_bit_no_filter: assert property (p_eight_bit_no_filter) else $error("lost"); // RULE1

    property p_head_parity_error_flag;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && push && cnt_ff == '0 && !flush) |=> (head_parity_error_flag == $past(rx_parity_error_flag));
    endproperty
    a_head_parity_error_flag: assert property (p_head_parity_error_flag) else $error("parity flag wrong"); // RULE4

    property p_head_framing_error_flag;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && push && cnt_ff == '0 && !flush) |=> (head_framing_error_flag == $past(rx_framing_error_flag));
    endproperty
    a_head_framing_error_flag: assert property (p_head_framing_error_flag) else $error("framing flag wrong"); // RULE5

    property p_last_pop_clears;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && pop && cnt_ff == CNT_W'(1) && !push) |=> !head_parity_error_flag && !head_framing_error_flag && !avail;
    endproperty
    a_last_pop_clears: assert property (p_last_pop_clears) else $error("stale flags"); // RULE10

endmodule // ursf_uart_rx_status

// ==== ursf_tx_model.sv ====
`timescale 1ns/1ps
module ursf_tx_model #(
    parameter int DIV = 8
) (
    // Clock
    input wire logic i_mclk,
    // Serial line, idle high
    output logic o_txd = 1'h1
);
    // ==========================================
    // Frame: start, data LSB first, even parity, stop
    task automatic send(input logic [8:0] c, input int nb, input logic pe, pf, stp);
        logic p;
        p = pf;
        o_txd <= 1'h0;
        repeat (DIV) @(posedge i_mclk);
        for (int i = 0; i < nb; i++) begin
            o_txd <= c[i];
            p ^= c[i];
            repeat (DIV) @(posedge i_mclk);
        end
        if (pe) begin
            o_txd <= p;
            repeat (DIV) @(posedge i_mclk);
        end
        // Stop may be forced low to provoke a framing fault
        o_txd <= stp;
        repeat (DIV) @(posedge i_mclk);
        o_txd <= 1'h1;
        repeat (2 * DIV) @(posedge i_mclk);
    endtask
endmodule // ursf_tx_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench import ursf_pkg::*;;
    // ==========================================
    // Signals and expected rows
    typedef struct packed {logic [15:0] ctl; logic [8:0] ch, dat;
        logic pf, stp; logic [7:0] sta;} ursf_row_t;
    ursf_row_t rows [7] = '{
        '{16'h0000, 9'h0A5, 9'h0A5, 1'h0, 1'h1, 8'h11},
        '{16'h0200, 9'h0A5, 9'h0A5, 1'h1, 1'h1, 8'h19},
        '{16'h0000, 9'h03C, 9'h03C, 1'h0, 1'h0, 8'h15},
        '{16'h0100, 9'h1C3, 9'h1C3, 1'h0, 1'h1, 8'h11},
        '{16'h0120, 9'h0C3, 9'h000, 1'h0, 1'h1, 8'h10},
        '{16'h0120, 9'h1C3, 9'h1C3, 1'h0, 1'h1, 8'h11},
        '{16'h0020, 9'h0C3, 9'h0C3, 1'h0, 1'h1, 8'h11}};
    ursf_row_t w;
    logic clk, rst_n, awv, wv, bready, arv, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic [1:0] r;
    wire logic awready, wready, bvalid, arready, rvalid, irq, rxd;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int errors = 0;
    int tests_run = 0;

    ursf_uart_rx_status u_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'h1),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
        .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arv), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .i_rxd(rxd), .o_irq(irq));
    ursf_tx_model u_tx (.i_mclk(clk), .o_txd(rxd));

    // ==========================================
    // One bus transfer; handshakes judged at the negedge before the taking edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        awaddr <= a;
        araddr <= a;
        wdata <= v;
        {awv, wv, bready} <= {3{wr}};
        {arv, rready} <= {2{!wr}};
        do begin
            @(negedge clk);
            ta = (awv && awready) || (arv && arready);
            tw = wv && wready;
            tb = bvalid || rvalid;
            d = rdata;
            r = wr ? bresp : rresp;
            @(posedge clk);
            if (ta) {awv, arv} <= 2'h0;
            if (tw) wv <= 1'h0;
        end while (!tb);
        // Ready lines stay up; the next call drives them once, so no double assignment
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(d, e);
    endtask
    // Reset, check defaults, then shorten the bit time to match the model
    task automatic restart();
        rst_n <= 1'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        rc(OFF_DIV, {16'h0, DIV_RST});
        rc(OFF_STATUS, 32'h10);
        bus(1'h1, OFF_DIV, 32'h8);
        $display("reset done");
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================
    // Clock, watchdog (run needs about 1300 cycles) and main sequence
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
    initial begin
        {rst_n, awv, wv, bready, arv, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        restart();
        foreach (rows[k]) begin
            w = rows[k];
            bus(1'h1, OFF_STATUS, {16'h0, w.ctl});
            u_tx.send(w.ch, w.ctl[8] ? 9 : 8, w.ctl[9], w.pf, w.stp);
            rc(OFF_STATUS, {16'h0, w.ctl | w.sta});
            rc(OFF_RXDATA, {23'h0, w.dat});
            rc(OFF_STATUS, {16'h0, w.ctl | 16'h10});
            $display("row %0d done", k);
        end
        // Events latched while masked keep the line low
        rc(OFF_IRQ_STAT, 32'h5);
        chk(irq, 32'h0);
        restart();
        bus(1'h1, OFF_IRQ_EN, 32'h7);
        u_tx.send(9'h001, 8, 1'h0, 1'h0, 1'h0);
        for (int i = 2; i < 5; i++) begin
            u_tx.send(9'(i), 8, 1'h0, 1'h0, 1'h1);
        end
        // Fifth character overflows the four-deep buffer
        fork
            u_tx.send(9'h005, 8, 1'h0, 1'h0, 1'h1);
            begin
                repeat (30) @(posedge clk);
                rc(OFF_STATUS, 32'h05);
            end
        join
        rc(OFF_STATUS, 32'h17);
        rc(OFF_IRQ_STAT, 32'h7);
        chk(irq, 32'h1);
        rc(OFF_RXDATA, 32'h1);
        rc(OFF_STATUS, 32'h13);
        rc(OFF_RXDATA, 32'h2);
        bus(1'h1, OFF_STATUS, 32'h0);
        rc(OFF_STATUS, 32'h10);
        bus(1'h1, OFF_STATUS, 32'h2);
        chk(r, RESP_OKAY);
        rc(OFF_STATUS, 32'h10);
        bus(1'h1, OFF_IRQ_CLR, 32'h7);
        chk(irq, 32'h0);
        rc(8'h20, 32'h0);
        chk(r, RESP_SLVERR);
        $display("overrun, interrupt and map done");
        give_verdict();
    end
endmodule // testbench
